/* module_reset_control.sv */
// Soft-reset state and hardware reset generation for the computer module.
//
// Function
// - Writing the soft-reset request bit to one enters and holds soft reset.
// - In soft reset: run light off, display blanked, keyboard and switch ignored.
// - Soft reset ends on bus clear, backplane reset, enabled watchdog reset, or power cycle.
// - Full hardware reset has four causes: backplane, switch, watchdog, power-on.
// - Backplane reset causes hardware reset only while its enable is set.
// - Watchdog expiry causes hardware reset only when its reset enable is set.
// - Watchdog runs continuously, period about 0.2 s or 6.7 s, event each period.
// - Any read of the module status/control register reloads the watchdog.
`timescale 1ns/10ps
`default_nettype none
`include "reset_ctl_consts.svh"
module module_reset_control #(
	parameter int unsigned WDOG_SHORT_CYC = `WDOG_SHORT_CYC,
	parameter int unsigned WDOG_LONG_CYC = `WDOG_LONG_CYC
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic soft_reset_request_set,
	input wire logic soft_reset_request_clear,
	input wire logic sysreset_enable,
	input wire logic backplane_sysreset,
	input wire logic panel_switch,
	input wire logic watchdog_reset_enable,
	input wire logic watchdog_long_period,
	input wire logic msc_read,
	input wire logic keyboard_in,
	output logic soft_reset_request_bit,
	output logic in_soft_reset,
	output logic hw_reset,
	output logic run_led,
	output logic display_blank,
	output logic keyboard_gated,
	output logic watchdog_event,
	output reset_ctl_pkg::reset_state_t state
);
	import reset_ctl_pkg::*;

	//--------------------------------------------------------------
	// Watchdog
	//--------------------------------------------------------------
	logic wd_expire;

	watchdog_counter #(
		.SHORT_CYC(WDOG_SHORT_CYC),
		.LONG_CYC(WDOG_LONG_CYC)
	) u_wdog (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.long_period(watchdog_long_period),
		.reload(msc_read),
		.expire_pulse(wd_expire)
	);

	assign watchdog_event = wd_expire;

	//--------------------------------------------------------------
	// Reset causes
	//--------------------------------------------------------------
	logic bp_cause;
	logic sw_cause;
	logic wd_cause;
	logic any_cause;
	logic [4:0] hold_ff;
	reset_state_t state_ff;

	assign bp_cause = backplane_sysreset && sysreset_enable;
	assign sw_cause = panel_switch && (state_ff != ST_SOFT_RESET);
	assign wd_cause = wd_expire && watchdog_reset_enable;
	assign any_cause = bp_cause || sw_cause || wd_cause;

	//--------------------------------------------------------------
	// Soft-reset request bit
	//--------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			soft_reset_request_bit <= `SOFT_RST_RESET;
		else if (clk_en)
		begin
			if (any_cause || backplane_sysreset)
				soft_reset_request_bit <= 1'b0;
			else if (soft_reset_request_set)
				soft_reset_request_bit <= 1'b1;
			else if (soft_reset_request_clear)
				soft_reset_request_bit <= 1'b0;
		end
	end

	//--------------------------------------------------------------
	// State machine
	//--------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			state_ff <= ST_POWER_ON;
			hold_ff <= 5'h00;
		end
		else if (clk_en)
		begin
			case (state_ff)
				ST_POWER_ON:
				begin
					hold_ff <= hold_ff + 5'h01;
					if (hold_ff == 5'(`PWRON_HOLD_CYC - 1))
						state_ff <= ST_RUN;
				end
				ST_RUN:
				begin
					if (any_cause)
						state_ff <= ST_HW_RESET;
					else if (soft_reset_request_bit)
						state_ff <= ST_SOFT_RESET;
				end
				ST_SOFT_RESET:
				begin
					if (bp_cause || wd_cause)
						state_ff <= ST_HW_RESET;
					else if (!soft_reset_request_bit)
						state_ff <= ST_RUN;
				end
				default:
				begin
					if (!any_cause)
						state_ff <= ST_RUN;
				end
			endcase
		end
	end

	assign state = state_ff;
	assign in_soft_reset = (state_ff == ST_SOFT_RESET);
	assign hw_reset = (state_ff == ST_HW_RESET) || (state_ff == ST_POWER_ON);
	assign run_led = (state_ff == ST_RUN);
	assign display_blank = (state_ff != ST_RUN);
	assign keyboard_gated = keyboard_in && (state_ff == ST_RUN);

	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------
	property p_set_enters;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && soft_reset_request_set && !any_cause && !backplane_sysreset)
		|=> soft_reset_request_bit;
	endproperty
	a_set_enters: assert property (p_set_enters) else $error("Request bit not set.");

	property p_dark;
		@(posedge core_clk) disable iff (!rst_n)
		in_soft_reset |-> (!run_led && display_blank && !keyboard_gated);
	endproperty
	a_dark: assert property (p_dark) else $error("Outputs active in soft reset.");

	property p_switch_ignored;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && in_soft_reset && panel_switch && !bp_cause && !wd_cause)
		|=> state != ST_HW_RESET;
	endproperty
	a_switch_ignored: assert property (p_switch_ignored) else $error("Switch acted.");

	property p_stay;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && in_soft_reset && soft_reset_request_bit && !bp_cause && !wd_cause)
		|=> in_soft_reset;
	endproperty
	a_stay: assert property (p_stay) else $error("Left soft reset early.");

	property p_bp_gate;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && state == ST_RUN && backplane_sysreset && !sysreset_enable
		&& !sw_cause && !wd_cause) |=> state != ST_HW_RESET;
	endproperty
	a_bp_gate: assert property (p_bp_gate) else $error("Disabled backplane reset acted.");

	property p_wd_reset;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && state == ST_RUN && wd_expire && watchdog_reset_enable)
		|=> hw_reset;
	endproperty
	a_wd_reset: assert property (p_wd_reset) else $error("Watchdog reset missed.");

	property p_cause_reset;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && state == ST_RUN && any_cause) |=> state == ST_HW_RESET;
	endproperty
	a_cause_reset: assert property (p_cause_reset) else $error("No hardware reset.");

	property p_reload;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && msc_read) |=> !wd_expire;
	endproperty
	a_reload: assert property (p_reload) else $error("Expiry after reload.");

	property p_clear_on_hw;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && any_cause) |=> !soft_reset_request_bit;
	endproperty
	a_clear_on_hw: assert property (p_clear_on_hw) else $error("Request bit survived.");

	// Entry into soft reset takes two steps: the bit is taken, then the state follows.
	sequence s_set_in_run;
		clk_en && state == ST_RUN && soft_reset_request_set && !any_cause && !backplane_sysreset;
	endsequence

	sequence s_quiet_step;
		clk_en && !any_cause && !backplane_sysreset;
	endsequence

	property p_enter_walk;
		@(posedge core_clk) disable iff (!rst_n)
		s_set_in_run ##1 s_quiet_step |=> in_soft_reset;
	endproperty
	a_enter_walk: assert property (p_enter_walk) else $error("Soft reset not entered.");

	property p_hw_release;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && state == ST_HW_RESET && !any_cause) |=> state == ST_RUN;
	endproperty
	a_hw_release: assert property (p_hw_release) else $error("Hardware reset held.");

	property p_pwron_hold;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && state == ST_POWER_ON && hold_ff != 5'(`PWRON_HOLD_CYC - 1))
		|=> state == ST_POWER_ON;
	endproperty
	a_pwron_hold: assert property (p_pwron_hold) else $error("Power-on hold cut short.");
endmodule
`default_nettype wire

/* reset_ctl_consts.svh */
// Timing counts and reset values for the module reset controller.
`ifndef RESET_CTL_CONSTS_SVH
`define RESET_CTL_CONSTS_SVH
`define CLK_PERIOD_NS 10
`define WDOG_SHORT_MS 200
`define WDOG_LONG_MS 6700
// The cycle counts are scaled in two steps so that no product leaves 32-bit integer range.
`define WDOG_SHORT_CYC (((`WDOG_SHORT_MS * 1000) / `CLK_PERIOD_NS) * 1000)
`define WDOG_LONG_CYC (((`WDOG_LONG_MS * 1000) / `CLK_PERIOD_NS) * 1000)
`define PWRON_HOLD_CYC 16
`define SOFT_RST_RESET 1'b0
`endif

/* reset_ctl_pkg.sv */
// Types shared by the module reset controller.
package reset_ctl_pkg;
	typedef enum logic [1:0] {
		ST_POWER_ON = 2'b00,
		ST_RUN = 2'b01,
		ST_SOFT_RESET = 2'b10,
		ST_HW_RESET = 2'b11
	} reset_state_t;
endpackage

/* watchdog_counter.sv */
// Free-running watchdog down-counter with two selectable periods.
`timescale 1ns/10ps
`default_nettype none
module watchdog_counter #(
	parameter int unsigned SHORT_CYC = 20000000,
	parameter int unsigned LONG_CYC = 670000000
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic long_period,
	input wire logic reload,
	output logic expire_pulse
);
	logic [31:0] count_ff;
	logic [31:0] period;

	assign period = long_period ? LONG_CYC : SHORT_CYC;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			count_ff <= SHORT_CYC - 1;
			expire_pulse <= 1'b0;
		end
		else if (clk_en)
		begin
			expire_pulse <= 1'b0;
			if (reload)
				count_ff <= period - 1;
			else if (count_ff == 32'h0000_0000)
			begin
				count_ff <= period - 1;
				expire_pulse <= 1'b1;
			end
			else
				count_ff <= count_ff - 32'h0000_0001;
		end
	end
endmodule
`default_nettype wire

/* bus_peer.sv */
// Model of the other bus module and the backplane reset line.
`timescale 1ns/10ps
`default_nettype none
module bus_peer (
	input wire logic core_clk,
	output logic req_set,
	output logic req_clear,
	output logic sysreset
);
	initial
	begin
		req_set = 1'b0;
		req_clear = 1'b0;
		sysreset = 1'b0;
	end
	task set_bit;
		@(negedge core_clk) req_set = 1'b1;
		@(negedge core_clk) req_set = 1'b0;
	endtask
	task clear_bit;
		@(negedge core_clk) req_clear = 1'b1;
		@(negedge core_clk) req_clear = 1'b0;
	endtask
	task drive_reset(input logic v);
		@(negedge core_clk) sysreset = v;
	endtask
endmodule
`default_nettype wire

/* tb_module_reset_control.sv */
// Self-checking bench for the module reset controller.
`timescale 1ns/10ps
`default_nettype none
module tb_module_reset_control;
	import reset_ctl_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic sr_en = 1'b0, sw = 1'b0, wd_en = 1'b0, wd_long = 1'b0, rd = 1'b0, kb = 1'b1;
	logic set_p, clr_p, sysrst, bit_q, in_sr, hw, led, blank, kb_g, ev;
	logic ce = 1'b1;
	reset_state_t st;
	int err_count = 0;
	int checks_done = 0;
	int n;
	logic hs;
	always #5 core_clk = ~core_clk;
	bus_peer i_peer (.core_clk(core_clk), .req_set(set_p), .req_clear(clr_p), .sysreset(sysrst));
	module_reset_control #(.WDOG_SHORT_CYC(8), .WDOG_LONG_CYC(20)) i_dut (.core_clk(core_clk),
		.rst_n(rst_n), .clk_en(ce), .soft_reset_request_set(set_p),
		.soft_reset_request_clear(clr_p), .sysreset_enable(sr_en), .backplane_sysreset(sysrst),
		.panel_switch(sw), .watchdog_reset_enable(wd_en), .watchdog_long_period(wd_long),
		.msc_read(rd), .keyboard_in(kb), .soft_reset_request_bit(bit_q), .in_soft_reset(in_sr),
		.hw_reset(hw), .run_led(led), .display_blank(blank), .keyboard_gated(kb_g),
		.watchdog_event(ev), .state(st));
	task give_verdict;
		if (err_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task cyc(input int c);
		repeat (c) @(negedge core_clk);
	endtask
	// Waits a bounded time for the run state, then checks the run outputs.
	task wait_run;
		for (int i = 0; i < 40 && st !== ST_RUN; i++)
			cyc(1);
		chk({led, blank, hw, st}, {3'b100, ST_RUN});
		if (st !== ST_RUN)
			give_verdict();
	endtask
	// Counts watchdog events and notes any hardware reset over c cycles.
	task count_ev(input int c);
		n = 0;
		hs = 1'b0;
		for (int i = 0; i < c; i++)
		begin
			cyc(1);
			rd = 1'b0;
			n += (ev === 1'b1);
			hs |= hw;
		end
	endtask
	task t_soft;
		i_peer.set_bit();
		cyc(2);
		chk({bit_q, in_sr, led, blank, kb_g}, 8'h1A);
		sw = 1'b1;
		cyc(3);
		chk({hw, in_sr}, 8'h01);
		sw = 1'b0;
		i_peer.clear_bit();
		cyc(2);
		chk({bit_q, st}, {1'b0, ST_RUN});
	endtask
	task t_backplane;
		i_peer.set_bit();
		cyc(2);
		i_peer.drive_reset(1'b1);
		cyc(3);
		chk({hw, bit_q, in_sr}, 8'h00);
		i_peer.drive_reset(1'b0);
		sr_en = 1'b1;
		i_peer.set_bit();
		cyc(2);
		i_peer.drive_reset(1'b1);
		cyc(2);
		chk({hw, bit_q, in_sr}, 8'h04);
		i_peer.drive_reset(1'b0);
		wait_run();
	endtask
	task t_watchdog;
		for (int i = 0; i < 6; i++)
		begin
			rd = 1'b1;
			count_ev(4);
			chk({n[3:0], hs}, 8'h00);
		end
		count_ev(32);
		chk({n[3:0], hs}, 8'h08);
		wd_long = 1'b1;
		rd = 1'b1;
		count_ev(50);
		chk({n[3:0], hs}, 8'h04);
		wd_long = 1'b0;
		wd_en = 1'b1;
		count_ev(12);
		chk(hs, 1'b1);
		wd_en = 1'b0;
		wait_run();
	endtask
	// Keyboard passes in run; with the clock enable low nothing may advance.
	task t_freeze;
		kb = 1'b0;
		cyc(1);
		chk(kb_g, 1'b0);
		kb = 1'b1;
		cyc(1);
		chk(kb_g, 1'b1);
		ce = 1'b0;
		sw = 1'b1;
		count_ev(20);
		chk({n[3:0], hs, st}, {4'h0, 1'b0, ST_RUN});
		sw = 1'b0;
		ce = 1'b1;
		count_ev(16);
		chk({n[3:0], hs}, 8'h04);
	endtask
	// A power cycle during soft reset ends soft reset and clears the request bit.
	task t_power;
		i_peer.set_bit();
		cyc(2);
		chk(in_sr, 1'b1);
		rst_n = 1'b0;
		cyc(2);
		chk({hw, bit_q, in_sr, st}, {3'b100, ST_POWER_ON});
		rst_n = 1'b1;
		wait_run();
		chk({bit_q, in_sr}, 8'h00);
	endtask
	initial
	begin
		cyc(10);
		chk({hw, bit_q, ev, st}, {3'b100, ST_POWER_ON});
		rst_n = 1'b1;
		wait_run();
		t_soft();
		sw = 1'b1;
		cyc(2);
		chk(hw, 1'b1);
		sw = 1'b0;
		wait_run();
		t_backplane();
		t_watchdog();
		t_freeze();
		t_power();
		give_verdict();
	end
endmodule
`default_nettype wire
